// *** hw/vfs_pkg.sv ***
// Shared constants, types and decoders of the video frame sync logic
package vfs_pkg;
   // APB geometry
   localparam int VFS_DW = 32;
   localparam int VFS_AW = 8;
   // Register byte offsets
   localparam logic [VFS_AW-1:0] VFS_CTRL_OFF = 8'h00;
   localparam logic [VFS_AW-1:0] VFS_THR_OFF = 8'h04;
   localparam logic [VFS_AW-1:0] VFS_COEF_OFF = 8'h08;
   localparam logic [VFS_AW-1:0] VFS_STAT_OFF = 8'h0c;
   localparam logic [VFS_AW-1:0] VFS_ISTAT_OFF = 8'h10;
   localparam logic [VFS_AW-1:0] VFS_IMASK_OFF = 8'h14;
   localparam logic [VFS_AW-1:0] VFS_CNT_OFF = 8'h18;
   // Control fields and reset values
   localparam int VFS_CTRL_EN_BIT = 0;
   localparam int VFS_CTRL_INV_BIT = 1;
   localparam logic [1:0] VFS_CTRL_RST = 2'h1;
   // Threshold fields, full 0..255 range each
   localparam int VFS_THR_W = 8;
   localparam int VFS_THR_LO_LSB = 0;
   localparam int VFS_THR_HI_LSB = 8;
   localparam logic [VFS_THR_W-1:0] VFS_THR_LO_RST = 8'h00;
   localparam logic [VFS_THR_W-1:0] VFS_THR_HI_RST = 8'hff;
   localparam logic [VFS_DW-1:0] VFS_COEF_RST = 32'h0000_0000;
   // Status register bits
   localparam int VFS_ST_BUSY_BIT = 0;
   localparam int VFS_ST_PEND_BIT = 1;
   localparam int VFS_ST_RUN_BIT = 2;
   // Interrupt event bits
   localparam int VFS_EV_W = 3;
   localparam int VFS_EV_RD = 0;
   localparam int VFS_EV_WR = 1;
   localparam int VFS_EV_OVR = 2;
   localparam logic [VFS_EV_W-1:0] VFS_EV_RST = 3'h0;
   // Frame counter fields
   localparam int VFS_CNT_W = 16;
   localparam int VFS_CNT_WR_LSB = 16;
   // DMA test vector taps
   localparam int VFS_TV_W = 33;
   localparam int VFS_TV_RD_BIT = 1;
   localparam int VFS_TV_WR_BIT = 32;
   // Control windows of the DMA engine and the edge filter, 64K each
   localparam logic [31:0] VFS_DMA_BASE = 32'h44a2_0000;
   localparam logic [31:0] VFS_FILT_BASE = 32'h44a3_0000;
   localparam logic [31:0] VFS_WIN_SPAN = 32'h0001_0000;
   // Frame pacing: 1080p at 24 frames per second on a 10 MHz clock
   localparam int VFS_CLK_HZ = 10_000_000;
   localparam int VFS_FRAME_RATE = 24;
   localparam int VFS_FRAME_CYC = VFS_CLK_HZ / VFS_FRAME_RATE;
   // Frame sequencer states
   typedef enum logic {VFS_IDLE, VFS_READING} vfs_state_t;
   // Window decode: bit 0 selects the DMA engine, bit 1 the filter
   function automatic logic [1:0] vfs_win_decode(input logic [31:0] a);
      logic [1:0] s;
      s = 2'h0;
      s[0] = (a >= VFS_DMA_BASE) && (a < VFS_DMA_BASE + VFS_WIN_SPAN);
      s[1] = (a >= VFS_FILT_BASE) && (a < VFS_FILT_BASE + VFS_WIN_SPAN);
      return s;
   endfunction : vfs_win_decode
endpackage : vfs_pkg

// *** hw/vfs_edge.sv ***
// Rising edge detector for level indications
`timescale 1ns/1ps
module vfs_edge (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic level,
   output logic rise
);
   // Previous sample of the level
   logic prev_r;

   // Sample history; starts low so a level high at release counts once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= level;
      end
   end

   // One-cycle pulse on each low-to-high change
   always_comb begin
      rise = level & ~prev_r;
   end
endmodule : vfs_edge

// *** hw/vfs_frame_timer.sv ***
// Frame period watchdog for the read channel
`timescale 1ns/1ps
module vfs_frame_timer #(
   parameter int CYC = 416666
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic stop,
   output logic expire
);
   localparam int CW = $clog2(CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(CYC - 1);

   // Refuse a period the counter cannot time
   if (CYC < 2) begin : g_chk
      $error("vfs_frame_timer: CYC must be at least 2");
   end

   // Running count and armed flag
   logic [CW-1:0] cnt_r;
   logic armed_r;

   // Count from start; a stop or an expiry disarms
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         armed_r <= 1'b0;
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (start) begin
            cnt_r <= '0;
            armed_r <= 1'b1;
         end else if (stop) begin
            armed_r <= 1'b0;
         end else if (armed_r) begin
            if (cnt_r == LAST) begin
               armed_r <= 1'b0;
               expire <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
   end
endmodule : vfs_frame_timer

// *** hw/vfs_frame_sync.sv ***
// Frame synchronisation between host doorbells and the video DMA engine
//
// Summary of operation
// RL1 - Frame start once doorbell seen and read done
// RL2 - Clear doorbell status after taking it
// RL3 - One host interrupt per written frame
// RL4 - Read done comes from test vector bit 1
// RL5 - Write done comes from test vector bit 32
// RL6 - Hold early doorbell until read completes
// RL7 - Host rings doorbell after each frame copy
// RL8 - Engine cycles three buffers per direction
// RL9 - Software fixes contiguous 8 MB buffers
// RL10 - Engine channels run free, externally paced
// RL11 - Frame start marker rides the sideband
// RL12 - Decode engine and filter 64K windows
// RL13 - Sustain 1080p at 24 frames/second
// RL14 - Thresholds accept 0 through 255
// RL15 - Coefficients at init; thresholds update live
// RL16 - Filter interrupt unused; write done instead
// RL17 - Reset drops pending doorbell, no starts
`timescale 1ns/1ps
module vfs_frame_sync
   import vfs_pkg::*;
#(
   parameter int FRAME_CYC = vfs_pkg::VFS_FRAME_CYC,
   parameter int TV_W = vfs_pkg::VFS_TV_W
) (
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [vfs_pkg::VFS_AW-1:0] paddr,
   input wire logic [vfs_pkg::VFS_DW-1:0] pwdata,
   output logic [vfs_pkg::VFS_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // Host doorbell interrupt and its status clear
   input wire logic host_irq,
   output logic host_irq_clear,
   // Video DMA engine
   input wire logic [TV_W-1:0] dma_test_vec,
   output logic read_frame_sync_in,
   output logic pcie_irq_assert,
   // Write stream towards the engine, marker on its sideband
   input wire logic wr_tvalid,
   input wire logic wr_tready,
   output logic write_sideband_sync,
   // Control interconnect window select
   input wire logic [31:0] ctrl_addr,
   output logic sel_dma,
   output logic sel_filter,
   // Edge filter settings
   output logic [vfs_pkg::VFS_THR_W-1:0] thr_lo,
   output logic [vfs_pkg::VFS_THR_W-1:0] thr_hi,
   output logic invert,
   output logic [vfs_pkg::VFS_DW-1:0] coef
);
   // Refuse a test vector too narrow for the write-done tap
   if (TV_W <= VFS_TV_WR_BIT) begin : g_chk_tv
      $error("vfs_frame_sync: TV_W must exceed the write-done bit");
   end
   if (FRAME_CYC < 2) begin : g_chk_fc
      $error("vfs_frame_sync: FRAME_CYC must be at least 2");
   end

   // Sequencer state and its next value
   vfs_state_t st_r;
   vfs_state_t st_nxt;
   // Doorbell latched while a frame is still being read
   logic pending_r;
   logic pending_nxt;
   // Set by the first frame start; coefficient writes are ignored from then on
   logic running_r;
   // Control register: enable and pixel inversion
   logic [1:0] ctrl_r;
   // Sticky events and their mask
   logic [VFS_EV_W-1:0] istat_r;
   logic [VFS_EV_W-1:0] imask_r;
   // Frame counters
   logic [VFS_CNT_W-1:0] rd_cnt_r;
   logic [VFS_CNT_W-1:0] wr_cnt_r;
   // Edge pulses
   logic irq_edge;
   logic rd_edge;
   logic wr_edge;
   logic ovr_ev;
   // Frame start decision this cycle
   logic take;
   // APB strobes
   logic setup_ph;
   logic wr_acc;
   logic [VFS_EV_W-1:0] ev_set;

   // Doorbell from the host, taken on its rising edge
   vfs_edge u_irq_edge (
      .pclk(pclk),
      .presetn(presetn),
      .level(host_irq),
      .rise(irq_edge)
   );

   // RL4 read done tap
   vfs_edge u_rd_edge (
      .pclk(pclk),
      .presetn(presetn),
      .level(dma_test_vec[VFS_TV_RD_BIT]),
      .rise(rd_edge)
   );

   // RL5 write done tap
   vfs_edge u_wr_edge (
      .pclk(pclk),
      .presetn(presetn),
      .level(dma_test_vec[VFS_TV_WR_BIT]),
      .rise(wr_edge)
   );

   // RL13 frame period watchdog
   vfs_frame_timer #(
      .CYC(FRAME_CYC)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .start(take),
      .stop(rd_edge),
      .expire(ovr_ev)
   );

   // RL1 start decision
   always_comb begin
      take = (st_r == VFS_IDLE) && ctrl_r[VFS_CTRL_EN_BIT]
             && (pending_r || irq_edge);
   end

   // Sequencer next state
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         VFS_IDLE: begin
            if (take) begin
               st_nxt = VFS_READING;
            end
         end
         VFS_READING: begin
            // RL4 read done ends the frame
            if (rd_edge) begin
               st_nxt = VFS_IDLE;
            end
         end
         default: begin
            st_nxt = VFS_IDLE;
         end
      endcase
   end

   // RL6 pending doorbell; the older one is consumed first
   always_comb begin
      pending_nxt = pending_r;
      if (take && pending_r) begin
         pending_nxt = irq_edge;
      end else if (take) begin
         pending_nxt = 1'b0;
      end else if (irq_edge) begin
         pending_nxt = 1'b1;
      end
   end

   // RL17 reset drops the pending doorbell and the sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= VFS_IDLE;
         pending_r <= 1'b0;
         running_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         pending_r <= pending_nxt;
         if (take) begin
            running_r <= 1'b1;
         end
      end
   end

   // RL1 one-cycle frame start to the read channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_frame_sync_in <= 1'b0;
      end else begin
         read_frame_sync_in <= take;
      end
   end

   // RL2 clear the doorbell status once the doorbell is taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_irq_clear <= 1'b0;
      end else begin
         host_irq_clear <= irq_edge;
      end
   end

   // RL3 host interrupt only after the frame is in memory
   // RL16 the filter's own interrupt plays no part here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcie_irq_assert <= 1'b0;
      end else begin
         pcie_irq_assert <= wr_edge;
      end
   end

   // RL11 marker armed by each frame start, dropped on first beat
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_sideband_sync <= 1'b0;
      end else if (take) begin
         write_sideband_sync <= 1'b1;
      end else if (wr_tvalid && wr_tready) begin
         write_sideband_sync <= 1'b0;
      end
   end

   // RL12 window select, registered so the outputs are clean
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_dma <= 1'b0;
         sel_filter <= 1'b0;
      end else begin
         {sel_filter, sel_dma} <= vfs_win_decode(ctrl_addr);
      end
   end

   // Frame counters wrap; software reads both in one word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_cnt_r <= '0;
         wr_cnt_r <= '0;
      end else begin
         if (rd_edge) begin
            rd_cnt_r <= rd_cnt_r + 1'b1;
         end
         if (wr_edge) begin
            wr_cnt_r <= wr_cnt_r + 1'b1;
         end
      end
   end

   // APB phases; pready rises in the access cycle, no wait states
   always_comb begin
      setup_ph = psel && !penable;
      wr_acc = psel && penable && pready && pwrite;
   end

   // Ready flop: high exactly for the access phase after a setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup_ph;
      end
   end

   // Read data and error captured during setup, shown in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (setup_ph) begin
         prdata <= '0;
         pslverr <= 1'b0;
         if (!pwrite) begin
            case (paddr)
               VFS_CTRL_OFF: prdata[1:0] <= ctrl_r;
               VFS_THR_OFF: begin
                  prdata[VFS_THR_LO_LSB +: VFS_THR_W] <= thr_lo;
                  prdata[VFS_THR_HI_LSB +: VFS_THR_W] <= thr_hi;
               end
               VFS_COEF_OFF: prdata <= coef;
               VFS_STAT_OFF: begin
                  prdata[VFS_ST_BUSY_BIT] <= (st_r == VFS_READING);
                  prdata[VFS_ST_PEND_BIT] <= pending_r;
                  prdata[VFS_ST_RUN_BIT] <= running_r;
               end
               VFS_ISTAT_OFF: prdata[VFS_EV_W-1:0] <= istat_r;
               VFS_IMASK_OFF: prdata[VFS_EV_W-1:0] <= imask_r;
               VFS_CNT_OFF: begin
                  prdata[VFS_CNT_W-1:0] <= rd_cnt_r;
                  prdata[VFS_CNT_WR_LSB +: VFS_CNT_W] <= wr_cnt_r;
               end
               // Unmapped offsets answer with an error
               default: pslverr <= 1'b1;
            endcase
         end else begin
            // Writes outside the writable set are refused too
            case (paddr)
               VFS_CTRL_OFF, VFS_THR_OFF, VFS_COEF_OFF,
               VFS_ISTAT_OFF, VFS_IMASK_OFF: pslverr <= 1'b0;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Control register steers the sequencer and the filter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= VFS_CTRL_RST;
      end else if (wr_acc && paddr == VFS_CTRL_OFF) begin
         ctrl_r <= pwdata[1:0];
      end
   end

   // Inversion follows the control bit on the next edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         invert <= 1'b0;
      end else begin
         invert <= ctrl_r[VFS_CTRL_INV_BIT];
      end
   end

   // RL14 RL15 thresholds take any 8-bit value at any time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thr_lo <= VFS_THR_LO_RST;
         thr_hi <= VFS_THR_HI_RST;
      end else if (wr_acc && paddr == VFS_THR_OFF) begin
         thr_lo <= pwdata[VFS_THR_LO_LSB +: VFS_THR_W];
         thr_hi <= pwdata[VFS_THR_HI_LSB +: VFS_THR_W];
      end
   end

   // RL15 coefficients freeze once frames run, avoiding torn frames
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coef <= VFS_COEF_RST;
      end else if (wr_acc && paddr == VFS_COEF_OFF && !running_r) begin
         coef <= pwdata;
      end
   end

   // Event sources feeding the sticky bits
   always_comb begin
      ev_set = '0;
      ev_set[VFS_EV_RD] = rd_edge;
      ev_set[VFS_EV_WR] = wr_edge;
      ev_set[VFS_EV_OVR] = ovr_ev;
   end

   // Sticky events, write one to clear; a new event beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_r <= VFS_EV_RST;
      end else if (wr_acc && paddr == VFS_ISTAT_OFF) begin
         istat_r <= (istat_r & ~pwdata[VFS_EV_W-1:0]) | ev_set;
      end else begin
         istat_r <= istat_r | ev_set;
      end
   end

   // Interrupt mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imask_r <= VFS_EV_RST;
      end else if (wr_acc && paddr == VFS_IMASK_OFF) begin
         imask_r <= pwdata[VFS_EV_W-1:0];
      end
   end

   // Level interrupt, one cycle behind the sticky bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(istat_r & imask_r);
      end
   end

   // Checks on the sequencer and its outputs
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_take;
      st_r == VFS_IDLE && ctrl_r[VFS_CTRL_EN_BIT] && (pending_r || irq_edge);
   endsequence

   sequence s_start_out;
      read_frame_sync_in ##1 !read_frame_sync_in;
   endsequence

   sync_start_a: assert property (s_take |=> s_start_out) // RL1
      else $error("frame start not issued as one pulse");
   sync_cause_a: assert property (read_frame_sync_in |->
      $past(st_r) == VFS_IDLE && $past(pending_r || irq_edge)) // RL1
      else $error("frame start without doorbell");
   clear_follow_a: assert property (irq_edge |=> host_irq_clear) // RL2
      else $error("doorbell status not cleared");
   host_irq_a: assert property ($rose(dma_test_vec[VFS_TV_WR_BIT])
      |=> pcie_irq_assert ##1 !pcie_irq_assert) // RL3
      else $error("write done did not raise one host interrupt");
   read_done_a: assert property (st_r == VFS_READING
      && $rose(dma_test_vec[VFS_TV_RD_BIT]) |=> st_r == VFS_IDLE) // RL4
      else $error("read done did not end the frame");
   host_irq_cause_a: assert property (pcie_irq_assert
      |-> $past(dma_test_vec[VFS_TV_WR_BIT], 1)) // RL5
      else $error("host interrupt without write done");
   hold_pending_a: assert property (st_r == VFS_READING && irq_edge
      && !rd_edge |=> pending_r && !read_frame_sync_in) // RL6
      else $error("early doorbell lost or started a frame");
   sideband_mark_a: assert property (read_frame_sync_in
      |-> write_sideband_sync) // RL11
      else $error("frame marker not armed");
   thresh_live_a: assert property (wr_acc && paddr == VFS_THR_OFF
      |=> thr_hi == $past(pwdata[VFS_THR_HI_LSB +: VFS_THR_W])
      && thr_lo == $past(pwdata[VFS_THR_LO_LSB +: VFS_THR_W])) // RL14
      else $error("threshold update lost");
   coef_lock_a: assert property (running_r && wr_acc
      && paddr == VFS_COEF_OFF |=> $stable(coef)) // RL15
      else $error("coefficient changed while running");
   quiet_start_a: assert property (!pending_r && !irq_edge
      |=> !read_frame_sync_in) // RL17
      else $error("frame start with nothing pending");
endmodule : vfs_frame_sync

// *** tb/vfs_dma_model.sv ***
// Video DMA engine and doorbell model
`timescale 1ns/1ps
module vfs_dma_model
   import vfs_pkg::*;
(
   input wire logic pclk,
   input wire logic ring,
   input wire logic [7:0] rd_delay,
   input wire logic host_irq_clear,
   input wire logic read_frame_sync_in,
   output logic host_irq,
   output logic [VFS_TV_W-1:0] dma_test_vec,
   output logic wr_tvalid,
   output logic wr_tready,
   output logic ring_ev,
   output logic rdone_ev,
   output logic wdone_ev,
   output logic [31:0] buf_addr
);
   logic [7:0] cnt_r; // Read cycles left, 0 when idle
   logic [7:0] tail_r; // Cycles from read done to write done
   logic [1:0] buf_r; // Buffer in use
   logic [VFS_TV_W-1:0] noise_r; // Unused taps toggle so a wrong tap shows
   initial begin
      {host_irq, wr_tvalid, wr_tready, ring_ev, rdone_ev, wdone_ev} = 6'h0;
      {cnt_r, tail_r, buf_r} = 18'h0;
      noise_r = '0;
      dma_test_vec = '0;
   end
   assign buf_addr = 32'h1000_0000 + {7'h0, buf_r, 23'h0}; // Base is arbitrary
   always @(posedge pclk) begin
      ring_ev <= ring;
      if (ring) begin
         host_irq <= 1'b1;
      end else if (host_irq_clear) begin
         host_irq <= 1'b0;
      end
   end
   always @(posedge pclk) begin
      noise_r <= ~noise_r;
      dma_test_vec <= noise_r;
      dma_test_vec[VFS_TV_RD_BIT] <= 1'b0;
      dma_test_vec[VFS_TV_WR_BIT] <= 1'b0;
      // No beat accepted outside a frame
      {wr_tvalid, wr_tready} <= {noise_r[0], 1'b0};
      {rdone_ev, wdone_ev} <= 2'h0;
      if (read_frame_sync_in) begin
         cnt_r <= rd_delay;
      end else if (cnt_r != 8'h0) begin
         cnt_r <= cnt_r - 8'h1;
      end
      if (cnt_r == 8'h2) begin
         {wr_tvalid, wr_tready} <= 2'h3;
      end
      if (cnt_r == 8'h1) begin
         dma_test_vec[VFS_TV_RD_BIT] <= 1'b1;
         rdone_ev <= 1'b1;
         tail_r <= 8'h6;
         buf_r <= (buf_r == 2'h2) ? 2'h0 : buf_r + 2'h1;
      end else if (tail_r != 8'h0) begin
         tail_r <= tail_r - 8'h1;
      end
      if (tail_r == 8'h1) begin
         dma_test_vec[VFS_TV_WR_BIT] <= 1'b1;
         wdone_ev <= 1'b1;
      end
   end
endmodule : vfs_dma_model

// *** tb/vfs_frame_sync_tb_top.sv ***
// Self-checking testbench of the video frame sync logic
`timescale 1ns/1ps
module vfs_frame_sync_tb_top;
   import vfs_pkg::*;
   localparam int FCYC = 20; // Short frame period keeps overrun cases fast
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, invert;
   logic [VFS_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, coef, ctrl_addr, lfsr_r, d;
   logic host_irq, host_irq_clear, read_frame_sync_in, pcie_irq_assert;
   logic wr_tvalid, wr_tready, write_sideband_sync, sel_dma, sel_filter;
   logic [VFS_TV_W-1:0] dma_test_vec;
   logic [VFS_THR_W-1:0] thr_lo, thr_hi;
   logic ring, ring_ev, rdone_ev, wdone_ev, beat_d;
   logic busy = 1'b0; // Reference: frame read running
   logic pend = 1'b0; // Reference: doorbell held
   logic [7:0] rd_delay;
   logic [33:0] note; // Read flag, error, data
   logic [33:0] q_apb[$]; // APB notes
   int q_st[$], q_clr[$], q_pi[$]; // Cycles at which pulses are due
   int cyc = 0;
   int error_cnt = 0;
   int n_tests = 0;
   logic [31:0] rv[7] = '{32'h1, 32'hff00, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [31:0] wa[6] = '{32'h44a1_ffff, 32'h44a2_0000, 32'h44a2_ffff, 32'h44a3_0000,
      32'h44a3_ffff, 32'h44a4_0000}; // Window edges
   logic [1:0] ws[6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0}; // Expected selects

   vfs_frame_sync #(.FRAME_CYC(FCYC)) vfs_frame_sync_i (.*);
   vfs_dma_model vfs_dma_model_i (.*, .buf_addr());

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim();
      check(q_st.size() + q_clr.size() + q_pi.size() + q_apb.size(), 0);
      $display("counts: %0d compares, %0d mismatches", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic ran_out();
      error_cnt++;
      $display("unexpected at %0t: wait ran out", $time);
      end_sim();
   endtask : ran_out

   // One APB transfer; watcher checks its note
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      input logic [33:0] nt);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      q_apb.push_back(nt);
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) ran_out();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v, 34'h0);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] v);
      apb(1'b0, a, 32'h0, {2'h2, v});
   endtask : rd
   task automatic bad(input logic w, input logic [7:0] a);
      apb(w, a, 32'h0, {2'h1, 32'h0});
   endtask : bad
   task automatic bell();
      ring <= 1'b1;
      @(posedge pclk);
      ring <= 1'b0;
   endtask : bell
   task automatic settle();
      int n;
      n = 0;
      repeat (4) @(posedge pclk);
      while ((busy || pend || vfs_dma_model_i.cnt_r != 8'h0 ||
              vfs_dma_model_i.tail_r != 8'h0) && n < 300) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 300) ran_out();
      repeat (3) @(posedge pclk);
   endtask : settle

   // Reference: pulses due per event
   always @(posedge pclk) begin
      if (!presetn) begin
         busy = 1'b0;
         pend = 1'b0;
      end else begin
         if (ring_ev) begin
            q_clr.push_back(cyc + 1);
            if (busy) pend = 1'b1;
            else q_st.push_back(cyc + 1);
            busy = 1'b1;
         end
         if (rdone_ev) begin
            busy = pend;
            if (pend) q_st.push_back(cyc + 2);
            pend = 1'b0;
         end
         if (wdone_ev) q_pi.push_back(cyc + 1);
      end
   end

   // Watcher pops the oldest note
   always @(posedge pclk) begin
      beat_d <= wr_tvalid && wr_tready;
      if (psel && penable && pready === 1'b1) begin
         note = (q_apb.size() > 0) ? q_apb.pop_front() : 34'h3_ffff_ffff;
         check({pslverr, note[33] ? prdata : 32'h0}, note[32:0]);
      end
      if (read_frame_sync_in === 1'b1) begin
         check(q_st.size() > 0 ? q_st.pop_front() : -1, cyc);
         check(write_sideband_sync, 1'b1);
      end
      if (host_irq_clear === 1'b1) begin
         check(q_clr.size() > 0 ? q_clr.pop_front() : -1, cyc);
      end
      if (pcie_irq_assert === 1'b1) begin
         check(q_pi.size() > 0 ? q_pi.pop_front() : -1, cyc);
      end
      if (beat_d && read_frame_sync_in !== 1'b1) check(write_sideband_sync, 1'b0);
   end

   initial begin
      repeat (50000) @(posedge pclk);
      ran_out();
   end

   initial begin
      {presetn, psel, penable, pwrite, ring} = 5'h0;
      {paddr, pwdata, ctrl_addr} = '0;
      rd_delay = 8'h8;
      lfsr_r = 32'h0001_7b5a;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 7; i++) rd(8'(i * 4), rv[i]);
      bad(1'b0, 8'h1c);
      bad(1'b1, 8'h20);
      $display("test reset values done");
      // Threshold ends and random values
      for (int i = 0; i < 4; i++) begin
         lfsr_r = lfsr(lfsr_r);
         d = (i == 0) ? 32'h00ff : (i == 1) ? 32'hff00 : (lfsr_r & 32'hffff);
         wr(VFS_THR_OFF, d);
         @(posedge pclk);
         check({thr_hi, thr_lo}, d[15:0]);
         rd(VFS_THR_OFF, d);
      end
      wr(VFS_CTRL_OFF, 32'h3);
      @(posedge pclk);
      check(invert, 1'b1);
      wr(VFS_COEF_OFF, lfsr_r);
      @(posedge pclk);
      check(coef, lfsr_r);
      $display("test filter settings done");
      bell();
      settle();
      wr(VFS_COEF_OFF, ~lfsr_r);
      rd(VFS_COEF_OFF, lfsr_r);
      $display("test single frame done");
      // Doorbell during a read is held
      rd_delay <= 8'hc;
      bell();
      repeat (4) @(posedge pclk);
      bell();
      wr(VFS_CTRL_OFF, 32'h1);
      @(posedge pclk);
      check(invert, 1'b0);
      settle();
      $display("test held doorbell done");
      for (int i = 0; i < 4; i++) begin
         lfsr_r = lfsr(lfsr_r);
         rd_delay <= {4'h0, lfsr_r[3:0]} | 8'h4;
         bell();
         settle();
      end
      rd(VFS_CNT_OFF, 32'h0007_0007);
      rd(VFS_ISTAT_OFF, 32'h3);
      wr(VFS_ISTAT_OFF, 32'h1);
      rd(VFS_ISTAT_OFF, 32'h2);
      wr(VFS_ISTAT_OFF, 32'h2);
      $display("test frame stream done");
      // Overrun event: raised, masked, cleared
      wr(VFS_IMASK_OFF, 32'h4);
      rd_delay <= 8'(FCYC + 10);
      bell();
      settle();
      rd(VFS_ISTAT_OFF, 32'h7);
      check(irq, 1'b1);
      wr(VFS_IMASK_OFF, 32'h3);
      wr(VFS_ISTAT_OFF, 32'h3);
      repeat (2) @(posedge pclk);
      check(irq, 1'b0);
      wr(VFS_IMASK_OFF, 32'h4);
      repeat (2) @(posedge pclk);
      check(irq, 1'b1);
      wr(VFS_ISTAT_OFF, 32'h4);
      repeat (2) @(posedge pclk);
      check(irq, 1'b0);
      $display("test interrupt done");
      for (int i = 0; i < 6; i++) begin
         ctrl_addr <= wa[i];
         repeat (2) @(posedge pclk);
         check({sel_filter, sel_dma}, ws[i]);
      end
      $display("test window decode done");
      // Reset drops a held doorbell
      rd_delay <= 8'hf;
      bell();
      repeat (4) @(posedge pclk);
      bell();
      repeat (4) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      bell();
      settle();
      $display("test reset mid frame done");
      end_sim();
   end
endmodule : vfs_frame_sync_tb_top
